// ### bench/tlac_sensor_model.sv
// Behavioural model of the three external temperature sensors
`timescale 1ns/10ps
module tlac_sensor_model (
   // Clock
   input wire logic core_clk,
   // Readings towards the monitor
   output logic [7:0] temperature_channel_1,
   output logic [7:0] temperature_channel_2,
   output logic [7:0] temperature_channel_3
);
   initial begin
      temperature_channel_1 = 8'h19;
      temperature_channel_2 = 8'h19;
      temperature_channel_3 = 8'h19;
   end
   // New reading lands just after an edge, like a finished conversion
   task automatic set_temp(input int ch, input logic [7:0] t);
      @(posedge core_clk);
      case (ch)
         1: temperature_channel_1 <= t;
         2: temperature_channel_2 <= t;
         default: temperature_channel_3 <= t;
      endcase
   endtask
endmodule

// ### bench/tlac_top_chk.sv
// Concurrent checks on the ports of the temperature alarm register bank
`timescale 1ns/10ps
module tlac_top_chk (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Sensor kind and alarm outputs
   input wire logic ch1_sensor_kind,
   input wire logic ch2_sensor_kind,
   input wire logic ch3_sensor_kind,
   input wire logic buzzer,
   input wire logic over_temperature,
   input wire logic [2:0] alert,
   input wire logic irq
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   wire logic [2:0] kinds = {ch3_sensor_kind, ch2_sensor_kind, ch1_sensor_kind};

   property p_alert_off; alert == 3'h0; endproperty
   a_alert_off: assert property (p_alert_off) else $error("alert output raised");
   property p_kind_rst; $rose(rst_n) |-> kinds == 3'h7; endproperty
   a_kind_rst: assert property (p_kind_rst) else $error("sensor kind not junction after reset");
   property p_buzz_rsv; reg_rd && reg_addr == tlac_pkg::BUZZ_EN_OFS |=> (reg_rdata & 8'h11) == 8'h00; endproperty
   a_buzz_rsv: assert property (p_buzz_rsv) else $error("buzzer enable reserved bits set");
   property p_src_rsv; reg_rd && reg_addr == tlac_pkg::SRC_SEL_OFS |=> (reg_rdata & 8'hCC) == 8'h00; endproperty
   a_src_rsv: assert property (p_src_rsv) else $error("source select reserved bits set");
   property p_oe_read; reg_rd && reg_addr == tlac_pkg::OUT_EN_OFS |=> (reg_rdata & 8'hF1) == 8'h00; endproperty
   a_oe_read: assert property (p_oe_read) else $error("output enable read-only bits set");
   property p_hyst_rsv; reg_rd && reg_addr == tlac_pkg::HYST1_OFS |=> reg_rdata[3:0] == 4'h0; endproperty
   a_hyst_rsv: assert property (p_hyst_rsv) else $error("hysteresis low nibble set");
   property p_mech_off;
      reg_wr && reg_addr == tlac_pkg::OUT_EN_OFS && reg_wdata[3:1] == 3'h0 |=> !over_temperature;
   endproperty
   a_mech_off: assert property (p_mech_off) else $error("over temperature with mechanisms off");
   property p_buzz_off; reg_wr && reg_addr == tlac_pkg::BUZZ_EN_OFS && reg_wdata == 8'h00 |=> !buzzer; endproperty
   a_buzz_off: assert property (p_buzz_off) else $error("buzzer with no enables");
   property p_irq_masked;
      reg_wr && reg_addr == tlac_pkg::IRQ_MASK_OFS && reg_wdata == 8'h00 |=> !irq;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("interrupt with every source masked");
   property p_kind_write;
      reg_wr && reg_addr == tlac_pkg::SENSOR_KIND_OFS |=> {4'h0, kinds, 1'b0} == ($past(reg_wdata) & 8'h0E);
   endproperty
   a_kind_write: assert property (p_kind_write) else $error("sensor kind outputs not updated");
endmodule

bind tlac_top tlac_top_chk chk (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .ch1_sensor_kind, .ch2_sensor_kind, .ch3_sensor_kind, .buzzer, .over_temperature, .alert, .irq);

// ### bench/tlac_top_tb.sv
// Self-checking testbench for the temperature alarm register bank
`timescale 1ns/10ps
module tlac_top_tb;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] cpu_temp_digital = 8'h19, cpu_temp_sideband = 8'h19, hub_temp_max = 8'h19;
   logic [7:0] ch1_overtemp_limit = 8'h64, ch2_overtemp_limit = 8'h64, ch3_overtemp_limit = 8'h64;
   logic [7:0] ch1_high_limit = 8'h55, ch2_high_limit = 8'h55, ch3_high_limit = 8'h55;
   logic [3:0] ch2_hysteresis_value = 4'h3, ch3_hysteresis_value = 4'h3;
   wire logic [7:0] temperature_channel_1, temperature_channel_2, temperature_channel_3, reg_rdata;
   wire logic ch1_sensor_kind, ch2_sensor_kind, ch3_sensor_kind, buzzer, over_temperature, irq;
   wire logic [2:0] alert;
   int errors = 0;
   int num_checks = 0;

   always #50 core_clk = ~core_clk;

   tlac_sensor_model sensor (.core_clk, .temperature_channel_1, .temperature_channel_2, .temperature_channel_3);
   tlac_top uut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .temperature_channel_1,
      .temperature_channel_2, .temperature_channel_3, .cpu_temp_digital, .cpu_temp_sideband, .hub_temp_max,
      .ch1_overtemp_limit, .ch1_high_limit, .ch2_overtemp_limit, .ch2_high_limit, .ch3_overtemp_limit,
      .ch3_high_limit, .ch2_hysteresis_value, .ch3_hysteresis_value, .ch1_sensor_kind, .ch2_sensor_kind,
      .ch3_sensor_kind, .buzzer, .over_temperature, .alert, .irq);

   // ------------------------------
   // Bus and compare helpers
   // ------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      chk(reg_rdata, exp);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
   endtask
   task automatic put_src(input int s, input logic [7:0] v);
      if (s == 0) sensor.set_temp(1, v);
      else begin
         @(posedge core_clk);
         case (s)
            1: cpu_temp_digital <= v;
            2: cpu_temp_sideband <= v;
            default: hub_temp_max <= v;
         endcase
      end
   endtask

   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_regs;
      logic [7:0] ofs[9] = '{8'h63, 8'h64, 8'h66, 8'h6B, 8'h6C, 8'hF0, 8'hF1, 8'hF2, 8'h70};
      logic [7:0] rst[9] = '{8'h00, 8'h00, 8'h02, 8'h0E, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00};
      logic [7:0] wm[9] = '{8'hEE, 8'h33, 8'h0E, 8'h0E, 8'hF0, 8'h00, 8'hEE, 8'h00, 8'h00};
      for (int i = 0; i < 9; i++) begin
         rdchk(ofs[i], rst[i]);
         wr(ofs[i], 8'hFF);
         rdchk(ofs[i], wm[i]);
      end
      $display("regs test done");
   endtask
   task automatic t_buzz;
      @(posedge core_clk);
      ch2_hysteresis_value <= 4'h3;
      wr(8'h63, 8'h40);
      wr(8'hF1, 8'h40);
      sensor.set_temp(2, 8'h65);
      cyc(3);
      chk(buzzer, 1'b1);
      chk(irq, 1'b1);
      // Masking alone must drop the level while status stays sticky
      wr(8'hF1, 8'h00);
      cyc(1);
      chk(irq, 1'b0);
      wr(8'hF1, 8'h40);
      cyc(1);
      chk(irq, 1'b1);
      rdchk(8'hF0, 8'h44);
      rdchk(8'hF0, 8'h00);
      chk(irq, 1'b0);
      sensor.set_temp(2, 8'h61);
      cyc(3);
      chk(buzzer, 1'b1);
      sensor.set_temp(2, 8'h60);
      cyc(3);
      chk(buzzer, 1'b0);
      wr(8'h63, 8'h04);
      cyc(1);
      chk(buzzer, 1'b1);
      sensor.set_temp(2, 8'h19);
      cyc(3);
      chk(buzzer, 1'b0);
      $display("buzzer test done");
   endtask
   task automatic t_src;
      @(posedge core_clk);
      ch1_overtemp_limit <= 8'h64;
      wr(8'h6C, 8'h40);
      wr(8'h66, 8'h02);
      wr(8'h63, 8'h20);
      for (int s = 0; s < 4; s++) begin
         wr(8'h64, 8'((s << 4) | s));
         put_src((s + 1) % 4, 8'h70);
         rdchk(8'hF2, 8'h00);
         put_src((s + 1) % 4, 8'h19);
         put_src(s, 8'h70);
         cyc(3);
         chk(over_temperature, 1'b1);
         rdchk(8'hF2, 8'h22);
         put_src(s, 8'h60);
         cyc(3);
         chk(over_temperature, 1'b1);
         put_src(s, 8'h5F);
         cyc(3);
         chk(over_temperature, 1'b0);
         put_src(s, 8'h19);
      end
      $display("source test done");
   endtask
   task automatic t_misc;
      @(posedge core_clk);
      ch3_overtemp_limit <= 8'h50;
      wr(8'h63, 8'h00);
      sensor.set_temp(3, 8'h60);
      cyc(3);
      chk(over_temperature, 1'b0);
      wr(8'h66, 8'h08);
      cyc(1);
      chk(over_temperature, 1'b1);
      chk(alert, 3'h0);
      wr(8'h66, 8'h00);
      cyc(1);
      chk(over_temperature, 1'b0);
      wr(8'h6B, 8'h04);
      cyc(1);
      chk({ch3_sensor_kind, ch2_sensor_kind, ch1_sensor_kind}, 3'h2);
      $display("misc test done");
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      t_regs;
      t_buzz;
      t_src;
      t_misc;
      complete_run;
   end
   // Run needs well under 1000 cycles
   initial begin
      #200000;
      errors++;
      complete_run;
   end
endmodule

// ### verilog/tlac_hyst_cmp.sv
// Limit comparator with hysteresis release
`timescale 1ns/10ps
module tlac_hyst_cmp (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Compare inputs, 1 degree C units
   input wire logic [7:0] temp,
   input wire logic [7:0] limit,
   input wire logic [3:0] hyst,
   // Live indication
   output logic active
);
   logic active_next;
   logic above;
   logic below_release;

   // Sum form avoids underflow of limit minus hysteresis
   assign above = temp > limit;
   assign below_release = ({1'b0, temp} + {5'h00, hyst}) < {1'b0, limit};
   assign active_next = above ? 1'b1 : (below_release ? 1'b0 : active); // see [RQ12] see [RQ13]

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         active <= 1'b0;
      end else begin
         active <= active_next;
      end
   end
endmodule

// ### verilog/tlac_pkg.sv
// Constants for the temperature limit, alarm and configuration register bank
// How it works
// [RQ1] Bits 7..5 enable buzzer on overtemp ch3..1
// [RQ2] Bits 3..1 enable buzzer on high limit
// [RQ3] Bits 5-4 pick ch1 overtemp compare source
// [RQ4] Bits 1-0 pick ch1 high-limit compare source
// [RQ5] Source 1 digital CPU, 2 sideband CPU
// [RQ6] Source 3 picks hub maximum temperature
// [RQ7] Read-only alert enables, read zero, gate alerts
// [RQ8] Ch1 overtemp mechanism enabled after reset
// [RQ9] Ch3, ch2 overtemp mechanisms writable, reset off
// [RQ10] Sensor kind bits, 1 junction, reset 1
// [RQ11] Ch1 hysteresis nibble 7-4, reset 4h
// [RQ12] Ch1 condition releases below limit minus hysteresis
// [RQ13] Indications set above limit, clear below hysteresis
// [RQ14] Buzzer is OR of enabled conditions
package tlac_pkg;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] BUZZ_EN_OFS = 8'h63;
   localparam logic [7:0] SRC_SEL_OFS = 8'h64;
   localparam logic [7:0] OUT_EN_OFS = 8'h66;
   localparam logic [7:0] SENSOR_KIND_OFS = 8'h6B;
   localparam logic [7:0] HYST1_OFS = 8'h6C;
   localparam logic [7:0] IRQ_STATUS_OFS = 8'hF0;
   localparam logic [7:0] IRQ_MASK_OFS = 8'hF1;
   localparam logic [7:0] LIVE_STATUS_OFS = 8'hF2;

   // ---------------------------------------------------------------
   // Field layout and writable masks
   // ---------------------------------------------------------------
   localparam logic [7:0] BUZZ_EN_WMASK = 8'hEE;
   localparam logic [7:0] SRC_SEL_WMASK = 8'h33;
   localparam logic [7:0] OUT_EN_WMASK = 8'h0E;
   localparam logic [7:0] SENSOR_KIND_WMASK = 8'h0E;
   localparam logic [7:0] HYST1_WMASK = 8'hF0;
   localparam logic [7:0] EVENT_MASK = 8'hEE;
   localparam int OVT_SEL_LSB = 4;
   localparam int HIGH_SEL_LSB = 0;
   localparam int HYST1_LSB = 4;
   localparam int OVT_LSB = 5;
   localparam int HIGH_LSB = 1;
   localparam int ALERT_LSB = 5;

   // ---------------------------------------------------------------
   // Values after reset
   // ---------------------------------------------------------------
   localparam logic [7:0] BUZZ_EN_RST = 8'h00;
   localparam logic [7:0] SRC_SEL_RST = 8'h00;
   localparam logic [7:0] OUT_EN_RST = 8'h02;
   localparam logic [7:0] SENSOR_KIND_RST = 8'h0E;
   localparam logic [7:0] HYST1_RST = 8'h40;
   localparam logic [7:0] IRQ_MASK_RST = 8'h00;
   localparam logic [2:0] ALERT_EN_RST = 3'h0;

   // ---------------------------------------------------------------
   // Channel 1 compare sources
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      TLAC_SRC_LOCAL = 2'h0,
      TLAC_SRC_DIGITAL = 2'h1,
      TLAC_SRC_SIDEBAND = 2'h2,
      TLAC_SRC_HUB_MAX = 2'h3
   } tlac_src_t;

endpackage

// ### verilog/tlac_top.sv
// Temperature limit alarm routing and configuration register bank
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
module tlac_top (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Channel readings, 1 degree C units
   input wire logic [7:0] temperature_channel_1,
   input wire logic [7:0] temperature_channel_2,
   input wire logic [7:0] temperature_channel_3,
   // Digital temperature sources for channel 1
   input wire logic [7:0] cpu_temp_digital,
   input wire logic [7:0] cpu_temp_sideband,
   input wire logic [7:0] hub_temp_max,
   // Limits and channel 2/3 hysteresis
   input wire logic [7:0] ch1_overtemp_limit,
   input wire logic [7:0] ch1_high_limit,
   input wire logic [7:0] ch2_overtemp_limit,
   input wire logic [7:0] ch2_high_limit,
   input wire logic [7:0] ch3_overtemp_limit,
   input wire logic [7:0] ch3_high_limit,
   input wire logic [3:0] ch2_hysteresis_value,
   input wire logic [3:0] ch3_hysteresis_value,
   // Sensor kind to the analogue side
   output logic ch1_sensor_kind,
   output logic ch2_sensor_kind,
   output logic ch3_sensor_kind,
   // Alarm outputs
   output logic buzzer,
   output logic over_temperature,
   output logic [2:0] alert,
   output logic irq
);
   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0] buzz_en_reg;
   logic [7:0] src_sel_reg;
   logic [7:0] out_en_reg;
   logic [7:0] sensor_kind_reg;
   logic [7:0] hyst1_reg;
   logic [7:0] irq_mask_reg;
   logic [7:0] irq_status_reg;
   logic [7:0] live_prev_reg;
   logic [7:0] rdata_reg;
   logic [7:0] irq_status_next;
   logic [7:0] rdata_next;

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   logic wr_buzz;
   logic wr_src;
   logic wr_out;
   logic wr_kind;
   logic wr_hyst;
   logic wr_mask;
   logic rd_status;

   assign wr_buzz = reg_wr && (reg_addr == tlac_pkg::BUZZ_EN_OFS);
   assign wr_src = reg_wr && (reg_addr == tlac_pkg::SRC_SEL_OFS);
   assign wr_out = reg_wr && (reg_addr == tlac_pkg::OUT_EN_OFS);
   assign wr_kind = reg_wr && (reg_addr == tlac_pkg::SENSOR_KIND_OFS);
   assign wr_hyst = reg_wr && (reg_addr == tlac_pkg::HYST1_OFS);
   assign wr_mask = reg_wr && (reg_addr == tlac_pkg::IRQ_MASK_OFS);
   assign rd_status = reg_rd && (reg_addr == tlac_pkg::IRQ_STATUS_OFS);

   // ---------------------------------------------------------------
   // Channel 1 source selection
   // ---------------------------------------------------------------
   tlac_pkg::tlac_src_t ovt_src;
   tlac_pkg::tlac_src_t high_src;
   logic [7:0] ch1_ovt_temp;
   logic [7:0] ch1_high_temp;
   logic [3:0] ch1_hysteresis_value;

   assign ovt_src = tlac_pkg::tlac_src_t'(src_sel_reg[tlac_pkg::OVT_SEL_LSB +: 2]); // see [RQ3]
   assign high_src = tlac_pkg::tlac_src_t'(src_sel_reg[tlac_pkg::HIGH_SEL_LSB +: 2]); // see [RQ4]
   assign ch1_hysteresis_value = hyst1_reg[tlac_pkg::HYST1_LSB +: 4];

   assign ch1_ovt_temp =
      (ovt_src == tlac_pkg::TLAC_SRC_DIGITAL) ? cpu_temp_digital : // see [RQ5]
      (ovt_src == tlac_pkg::TLAC_SRC_SIDEBAND) ? cpu_temp_sideband :
      (ovt_src == tlac_pkg::TLAC_SRC_HUB_MAX) ? hub_temp_max : // see [RQ6]
      temperature_channel_1;
   assign ch1_high_temp =
      (high_src == tlac_pkg::TLAC_SRC_DIGITAL) ? cpu_temp_digital : // see [RQ5]
      (high_src == tlac_pkg::TLAC_SRC_SIDEBAND) ? cpu_temp_sideband :
      (high_src == tlac_pkg::TLAC_SRC_HUB_MAX) ? hub_temp_max : // see [RQ6]
      temperature_channel_1;

   // ---------------------------------------------------------------
   // Limit comparators
   // ---------------------------------------------------------------
   logic [2:0] ovt_live;
   logic [2:0] high_live;
   logic [7:0] live;

   tlac_hyst_cmp u_ovt1 (
      .core_clk(core_clk), .rst_n(rst_n), .temp(ch1_ovt_temp),
      .limit(ch1_overtemp_limit), .hyst(ch1_hysteresis_value), .active(ovt_live[0])
   );
   tlac_hyst_cmp u_ovt2 (
      .core_clk(core_clk), .rst_n(rst_n), .temp(temperature_channel_2),
      .limit(ch2_overtemp_limit), .hyst(ch2_hysteresis_value), .active(ovt_live[1])
   );
   tlac_hyst_cmp u_ovt3 (
      .core_clk(core_clk), .rst_n(rst_n), .temp(temperature_channel_3),
      .limit(ch3_overtemp_limit), .hyst(ch3_hysteresis_value), .active(ovt_live[2])
   );
   tlac_hyst_cmp u_high1 (
      .core_clk(core_clk), .rst_n(rst_n), .temp(ch1_high_temp),
      .limit(ch1_high_limit), .hyst(ch1_hysteresis_value), .active(high_live[0])
   );
   tlac_hyst_cmp u_high2 (
      .core_clk(core_clk), .rst_n(rst_n), .temp(temperature_channel_2),
      .limit(ch2_high_limit), .hyst(ch2_hysteresis_value), .active(high_live[1])
   );
   tlac_hyst_cmp u_high3 (
      .core_clk(core_clk), .rst_n(rst_n), .temp(temperature_channel_3),
      .limit(ch3_high_limit), .hyst(ch3_hysteresis_value), .active(high_live[2])
   );

   assign live = {ovt_live, 1'b0, high_live, 1'b0};

   // ---------------------------------------------------------------
   // Alarm outputs
   // ---------------------------------------------------------------
   logic [2:0] ovt_buzz_en;
   logic [2:0] high_buzz_en;
   logic [2:0] ovt_mech_en;
   logic [2:0] alert_en;

   assign ovt_buzz_en = buzz_en_reg[tlac_pkg::OVT_LSB +: 3]; // see [RQ1]
   assign high_buzz_en = buzz_en_reg[tlac_pkg::HIGH_LSB +: 3]; // see [RQ2]
   assign ovt_mech_en = out_en_reg[tlac_pkg::HIGH_LSB +: 3]; // see [RQ8] see [RQ9]
   // Alert enables are read-only, so alerts stay quiet unless the reset value changes
   assign alert_en = tlac_pkg::ALERT_EN_RST; // see [RQ7]

   assign buzzer = |((ovt_live & ovt_buzz_en) | (high_live & high_buzz_en)); // see [RQ14]
   assign over_temperature = |(ovt_live & ovt_mech_en);
   assign alert = high_live & alert_en; // see [RQ7]
   assign ch1_sensor_kind = sensor_kind_reg[1]; // see [RQ10]
   assign ch2_sensor_kind = sensor_kind_reg[2];
   assign ch3_sensor_kind = sensor_kind_reg[3];

   // ---------------------------------------------------------------
   // Interrupt status: raising edges of live conditions
   // ---------------------------------------------------------------
   logic [7:0] irq_set;

   assign irq_set = live & ~live_prev_reg & tlac_pkg::EVENT_MASK;
   // A new event in the clearing read survives
   assign irq_status_next = (rd_status ? 8'h00 : irq_status_reg) | irq_set;
   assign irq = |(irq_status_reg & irq_mask_reg);

   // ---------------------------------------------------------------
   // Read mux
   // ---------------------------------------------------------------
   assign rdata_next =
      !reg_rd ? 8'h00 :
      (reg_addr == tlac_pkg::BUZZ_EN_OFS) ? buzz_en_reg :
      (reg_addr == tlac_pkg::SRC_SEL_OFS) ? src_sel_reg :
      (reg_addr == tlac_pkg::OUT_EN_OFS) ? ({alert_en, 5'h00} | out_en_reg) : // see [RQ7]
      (reg_addr == tlac_pkg::SENSOR_KIND_OFS) ? sensor_kind_reg :
      (reg_addr == tlac_pkg::HYST1_OFS) ? hyst1_reg : // see [RQ11]
      (reg_addr == tlac_pkg::IRQ_STATUS_OFS) ? irq_status_reg :
      (reg_addr == tlac_pkg::IRQ_MASK_OFS) ? irq_mask_reg :
      (reg_addr == tlac_pkg::LIVE_STATUS_OFS) ? live :
      8'h00;

   assign reg_rdata = rdata_reg;

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         buzz_en_reg <= tlac_pkg::BUZZ_EN_RST; // see [RQ1] see [RQ2]
         src_sel_reg <= tlac_pkg::SRC_SEL_RST; // see [RQ3] see [RQ4]
         out_en_reg <= tlac_pkg::OUT_EN_RST; // see [RQ8] see [RQ9]
         sensor_kind_reg <= tlac_pkg::SENSOR_KIND_RST; // see [RQ10]
         hyst1_reg <= tlac_pkg::HYST1_RST; // see [RQ11]
         irq_mask_reg <= tlac_pkg::IRQ_MASK_RST;
      end else begin
         if (wr_buzz) buzz_en_reg <= reg_wdata & tlac_pkg::BUZZ_EN_WMASK;
         if (wr_src) src_sel_reg <= reg_wdata & tlac_pkg::SRC_SEL_WMASK;
         if (wr_out) out_en_reg <= reg_wdata & tlac_pkg::OUT_EN_WMASK;
         if (wr_kind) sensor_kind_reg <= reg_wdata & tlac_pkg::SENSOR_KIND_WMASK;
         if (wr_hyst) hyst1_reg <= reg_wdata & tlac_pkg::HYST1_WMASK;
         if (wr_mask) irq_mask_reg <= reg_wdata & tlac_pkg::EVENT_MASK;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_status_reg <= 8'h00;
         live_prev_reg <= 8'h00;
         rdata_reg <= 8'h00;
      end else begin
         irq_status_reg <= irq_status_next;
         live_prev_reg <= live;
         rdata_reg <= rdata_next;
      end
   end
endmodule
